// [dv/tb_top.sv]
// Purpose: self-checking bench for the reference and excitation bank
// Assumes: strobe register port, read data one cycle after the read strobe
// Notes: expectations derive from field layouts and reset values
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import refexc_pkg::*;
;
	logic CLK_SYS, RST_N, WR, RD, POWER_DOWN, IRQ;
	logic [7:0] ADDR, WDATA, RDATA;
	logic REF_LOW_MON_EN, REF_THIRD_MON_EN, REF_PULL_EN;
	logic POS_BUF_EN, NEG_BUF_EN, INT_REF_ON, AMP_RAIL_MON_EN;
	logic LOW_SIDE_SWITCH, SRC1_COMMON, SRC2_COMMON;
	logic [1:0] REF_SOURCE;
	logic [11:0] CUR_MAG_UA, SRC1_PIN_SEL, SRC2_PIN_SEL;
	int errors = 0;
	int checked = 0;
	logic [11:0] mag_ua [16] = '{12'h000, 12'h00A, 12'h032, 12'h064,
		12'h0FA, 12'h1F4, 12'h2EE, 12'h3E8, 12'h5DC, 12'h7D0,
		12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

	refexc_ctrl refexc_ctrl_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.IRQ(IRQ), .POWER_DOWN(POWER_DOWN),
		.REF_LOW_MON_EN(REF_LOW_MON_EN), .REF_THIRD_MON_EN(REF_THIRD_MON_EN),
		.REF_PULL_EN(REF_PULL_EN), .POS_BUF_EN(POS_BUF_EN),
		.NEG_BUF_EN(NEG_BUF_EN), .REF_SOURCE(REF_SOURCE),
		.INT_REF_ON(INT_REF_ON), .AMP_RAIL_MON_EN(AMP_RAIL_MON_EN),
		.LOW_SIDE_SWITCH(LOW_SIDE_SWITCH), .CUR_MAG_UA(CUR_MAG_UA),
		.SRC1_PIN_SEL(SRC1_PIN_SEL), .SRC1_COMMON(SRC1_COMMON),
		.SRC2_PIN_SEL(SRC2_PIN_SEL), .SRC2_COMMON(SRC2_COMMON));

	task automatic conclude;
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1;
		chk({8'h00, RDATA}, {8'h00, exp});
	endtask

	// write then read the same address with no idle cycle between
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1;
		chk({8'h00, RDATA}, {8'h00, exp});
	endtask

	task automatic pd(input logic v);
		@(posedge CLK_SYS);
		POWER_DOWN <= v;
		@(posedge CLK_SYS);
		#1;
	endtask

	// expected {common, pin one-hot} for one route code
	function automatic logic [15:0] route_exp(input int r);
		return (r < 12) ? (16'h0001 << r) : {3'h0, r == 12, 12'h000};
	endfunction

	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	initial begin
		repeat (20000) @(posedge CLK_SYS);
		errors++;
		conclude();
	end

	initial begin
		RST_N = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		POWER_DOWN = 1'b0;
		repeat (20) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		rd(ADDR_REF_CTRL, 8'h10);
		rd(ADDR_EXC_MAG, 8'h00);
		rd(ADDR_EXC_ROUTE, 8'hFF);
		chk({7'h00, POS_BUF_EN, NEG_BUF_EN, REF_LOW_MON_EN, REF_SOURCE,
			INT_REF_ON, AMP_RAIL_MON_EN, LOW_SIDE_SWITCH, IRQ},
			16'h0100);
		chk({3'h0, SRC1_COMMON, SRC1_PIN_SEL | SRC2_PIN_SEL}, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_REF_CTRL, {m[1:0], m[1:0], 4'h0});
			chk({11'h000, REF_LOW_MON_EN, REF_THIRD_MON_EN, REF_PULL_EN,
				POS_BUF_EN, NEG_BUF_EN}, {11'h000, m != 0, m == 2, m == 3,
				~m[1], ~m[0]});
		end
		for (int s = 0; s < 4; s++)
			for (int c = 0; c < 4; c++) begin
				wr(ADDR_REF_CTRL, {4'h3, s[1:0], c[1:0]});
				rd(ADDR_REF_CTRL, {4'h3, s[1:0], c[1:0]});
				for (int p = 0; p < 2; p++) begin
					pd(p[0]);
					chk({13'h0000, REF_SOURCE, INT_REF_ON}, {13'h0000, s[1:0],
						c == 2 || (c == 1 && p == 0)});
				end
			end
		pd(1'b0);
		wr(ADDR_EXC_MAG, 8'hFF);
		rd(ADDR_EXC_MAG, 8'hCF);
		chk({14'h0000, AMP_RAIL_MON_EN, LOW_SIDE_SWITCH}, 16'h0003);
		pd(1'b1);
		chk({15'h0000, LOW_SIDE_SWITCH}, 16'h0000);
		pd(1'b0);
		for (int k = 0; k < 16; k++) begin
			wr(ADDR_EXC_MAG, {4'h0, k[3:0]});
			chk({4'h0, CUR_MAG_UA}, {4'h0, mag_ua[k]});
		end
		wr(ADDR_REF_CTRL, 8'h32); // internal reference on before currents
		for (int r = 0; r < 16; r++) begin
			wr(ADDR_EXC_ROUTE, {4'hF - r[3:0], r[3:0]});
			chk({3'h0, SRC1_COMMON, SRC1_PIN_SEL}, route_exp(r));
			chk({3'h0, SRC2_COMMON, SRC2_PIN_SEL}, route_exp(15 - r));
		end
		wr(ADDR_EXC_ROUTE, 8'hFF);
		wr(ADDR_EXC_MAG, 8'h00);
		wr(ADDR_REF_CTRL, 8'h10);
		wr(ADDR_IRQ_STATUS, 8'h07);
		rd(ADDR_IRQ_STATUS, 8'h00);
		wr(ADDR_IRQ_MASK, 8'h07);
		rd(ADDR_IRQ_MASK, 8'h07);
		wr(ADDR_EXC_MAG, 8'h05);
		wr(ADDR_EXC_ROUTE, 8'hFC);
		rd(ADDR_IRQ_STATUS, 8'h02);
		chk({15'h0000, IRQ}, 16'h0001);
		wr(ADDR_IRQ_MASK, 8'h05);
		chk({15'h0000, IRQ}, 16'h0000);
		wr(ADDR_EXC_ROUTE, 8'hFF);
		wr(ADDR_IRQ_STATUS, 8'h02);
		wr(ADDR_REF_CTRL, 8'h08);
		rd(ADDR_IRQ_STATUS, 8'h04);
		wr(ADDR_REF_CTRL, 8'h33);
		rd(ADDR_IRQ_STATUS, 8'h05);
		chk({15'h0000, IRQ}, 16'h0001);
		wr(ADDR_REF_CTRL, 8'h10);
		wr(ADDR_IRQ_STATUS, 8'h07);
		rd(ADDR_IRQ_STATUS, 8'h00);
		chk({15'h0000, IRQ}, 16'h0000);
		wr_rd(ADDR_REF_CTRL, 8'h61, 8'h61);
		wr_rd(ADDR_EXC_MAG, 8'h75, 8'h45);
		wr(ADDR_REF_CTRL, 8'h10);
		wr(8'h20, 8'hAA);
		rd(8'h20, 8'h00);
		rd(ADDR_REF_CTRL, 8'h10);
		@(posedge CLK_SYS);
		#1;
		chk({8'h00, RDATA}, 16'h0000);
		conclude();
	end
endmodule // tb_top
`default_nettype wire

// [shared/refexc_pkg.sv]
// Purpose: constants and types for the reference and excitation control bank
// Assumes: 8-bit registers reached over a plain strobe port
// Notes: status and mask registers sit beside the documented three
package refexc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_REF_CTRL = 8'h05;
	localparam logic [7:0] ADDR_EXC_MAG = 8'h06;
	localparam logic [7:0] ADDR_EXC_ROUTE = 8'h07;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h11;
	localparam logic [7:0] RST_REF_CTRL = 8'h10;
	localparam logic [7:0] RST_EXC_MAG = 8'h00;
	localparam logic [7:0] RST_EXC_ROUTE = 8'hFF;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] EXC_MAG_WMASK = 8'hCF;
	localparam int MON_MSB = 7;
	localparam int MON_LSB = 6;
	localparam int POS_BYP_BIT = 5;
	localparam int NEG_BYP_BIT = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 2;
	localparam int INT_MSB = 1;
	localparam int INT_LSB = 0;
	localparam int RAIL_BIT = 7;
	localparam int SW_BIT = 6;
	localparam int MAG_MSB = 3;
	localparam int MAG_LSB = 0;
	localparam int ROUTE2_MSB = 7;
	localparam int ROUTE2_LSB = 4;
	localparam int ROUTE1_MSB = 3;
	localparam int ROUTE1_LSB = 0;
	localparam logic [3:0] ROUTE_COMMON = 4'hC;
	localparam logic [3:0] MAG_MAX_CODE = 4'h9;
	// interrupt events: reserved code written, current enabled without int ref, int ref selected with a buffer not bypassed
	localparam int EV_RSV_CODE = 0;
	localparam int EV_NO_INTREF = 1;
	localparam int EV_BUF_CONFLICT = 2;
	localparam int EV_W = 3;
	typedef enum logic [1:0] {REFEXC_MON_OFF, REFEXC_MON_LOW, REFEXC_MON_BOTH,
		REFEXC_MON_PULL} refexc_mon_type;
	typedef enum logic [1:0] {REFEXC_REF_EXT0, REFEXC_REF_EXT1,
		REFEXC_REF_INT, REFEXC_REF_RSV} refexc_src_type;
	typedef enum logic [1:0] {REFEXC_INT_OFF, REFEXC_INT_ON_PD,
		REFEXC_INT_ALWAYS, REFEXC_INT_RSV} refexc_int_type;
endpackage

// [verilog/refexc_ctrl.sv]
// Purpose: reference and excitation current configuration registers
// Assumes: one clock, plain strobe register port, read data one cycle later
// Notes: analog controls are decoded for the analog side into enables, pin selects, a uA current and the raw source code
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module refexc_ctrl
	import refexc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic IRQ,
	input wire logic POWER_DOWN,
	output logic REF_LOW_MON_EN,
	output logic REF_THIRD_MON_EN,
	output logic REF_PULL_EN,
	output logic POS_BUF_EN,
	output logic NEG_BUF_EN,
	output logic [1:0] REF_SOURCE,
	output logic INT_REF_ON,
	output logic AMP_RAIL_MON_EN,
	output logic LOW_SIDE_SWITCH,
	output logic [11:0] CUR_MAG_UA,
	output logic [11:0] SRC1_PIN_SEL,
	output logic SRC1_COMMON,
	output logic [11:0] SRC2_PIN_SEL,
	output logic SRC2_COMMON
);
	typedef struct packed {
		logic [7:0] ref_ctrl;
		logic [7:0] exc_mag;
		logic [7:0] exc_route;
		logic [EV_W-1:0] irq_status;
		logic [EV_W-1:0] irq_mask;
		logic [7:0] rdata;
	} refexc_state_type;

	refexc_state_type state_reg, state_next;
	logic [EV_W-1:0] events;
	logic src1_conn, src2_conn;
	logic int_ref_active;

	default clocking cb_sys @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	function automatic logic [11:0] mag_to_ua(input logic [3:0] code);
		case (code)
			4'h1: mag_to_ua = 12'd10;
			4'h2: mag_to_ua = 12'd50;
			4'h3: mag_to_ua = 12'd100;
			4'h4: mag_to_ua = 12'd250;
			4'h5: mag_to_ua = 12'd500;
			4'h6: mag_to_ua = 12'd750;
			4'h7: mag_to_ua = 12'd1000;
			4'h8: mag_to_ua = 12'd1500;
			4'h9: mag_to_ua = 12'd2000;
			default: mag_to_ua = 12'd0;
		endcase
	endfunction

	function automatic logic [7:0] read_mux(input refexc_state_type s,
		input logic [7:0] a);
		case (a)
			ADDR_REF_CTRL: read_mux = s.ref_ctrl;
			ADDR_EXC_MAG: read_mux = s.exc_mag & EXC_MAG_WMASK;
			ADDR_EXC_ROUTE: read_mux = s.exc_route;
			ADDR_IRQ_STATUS: read_mux = {5'h00, s.irq_status};
			ADDR_IRQ_MASK: read_mux = {5'h00, s.irq_mask};
			default: read_mux = 8'h00;
		endcase
	endfunction

	// analog decode of the stored fields
	always_comb begin
		refexc_mon_type mon;
		refexc_int_type icfg;
		mon = refexc_mon_type'(state_reg.ref_ctrl[MON_MSB:MON_LSB]);
		icfg = refexc_int_type'(state_reg.ref_ctrl[INT_MSB:INT_LSB]);
		REF_LOW_MON_EN = (mon != REFEXC_MON_OFF);
		REF_THIRD_MON_EN = (mon == REFEXC_MON_BOTH);
		REF_PULL_EN = (mon == REFEXC_MON_PULL);
		POS_BUF_EN = ~state_reg.ref_ctrl[POS_BYP_BIT];
		NEG_BUF_EN = ~state_reg.ref_ctrl[NEG_BYP_BIT];
		REF_SOURCE = state_reg.ref_ctrl[SEL_MSB:SEL_LSB];
		// on-but-sleeps drops out in power-down, always-on does not
		int_ref_active = (icfg == REFEXC_INT_ALWAYS) ||
			((icfg == REFEXC_INT_ON_PD) && !POWER_DOWN);
		INT_REF_ON = int_ref_active;
		AMP_RAIL_MON_EN = state_reg.exc_mag[RAIL_BIT];
		LOW_SIDE_SWITCH = state_reg.exc_mag[SW_BIT] && !POWER_DOWN;
		CUR_MAG_UA = mag_to_ua(state_reg.exc_mag[MAG_MSB:MAG_LSB]);
	end

	refexc_route_dec u_route1 (
		.code(state_reg.exc_route[ROUTE1_MSB:ROUTE1_LSB]),
		.pin_sel(SRC1_PIN_SEL),
		.common_sel(SRC1_COMMON),
		.connected(src1_conn)
	);
	refexc_route_dec u_route2 (
		.code(state_reg.exc_route[ROUTE2_MSB:ROUTE2_LSB]),
		.pin_sel(SRC2_PIN_SEL),
		.common_sel(SRC2_COMMON),
		.connected(src2_conn)
	);

	// events flag software misuse that hardware does not block
	always_comb begin
		events = '0;
		events[EV_RSV_CODE] =
			(state_reg.ref_ctrl[SEL_MSB:SEL_LSB] == REFEXC_REF_RSV) ||
			(state_reg.ref_ctrl[INT_MSB:INT_LSB] == REFEXC_INT_RSV);
		events[EV_NO_INTREF] = (CUR_MAG_UA != 12'd0) &&
			(src1_conn || src2_conn) && !int_ref_active;
		events[EV_BUF_CONFLICT] =
			(state_reg.ref_ctrl[SEL_MSB:SEL_LSB] == REFEXC_REF_INT) &&
			!(state_reg.ref_ctrl[POS_BYP_BIT] &&
			state_reg.ref_ctrl[NEG_BYP_BIT]);
	end

	always_comb begin
		state_next = state_reg;
		state_next.rdata = 8'h00;
		if (RD) begin
			state_next.rdata = read_mux(state_reg, ADDR);
		end
		if (WR) begin
			case (ADDR)
				ADDR_REF_CTRL: state_next.ref_ctrl = WDATA;
				ADDR_EXC_MAG: state_next.exc_mag = WDATA & EXC_MAG_WMASK;
				ADDR_EXC_ROUTE: state_next.exc_route = WDATA;
				ADDR_IRQ_STATUS: state_next.irq_status =
					state_reg.irq_status & ~WDATA[EV_W-1:0];
				ADDR_IRQ_MASK: state_next.irq_mask = WDATA[EV_W-1:0];
				default: ;
			endcase
		end
		// set wins over a same-cycle clear
		state_next.irq_status = state_next.irq_status | events;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_reg.ref_ctrl <= RST_REF_CTRL;
			state_reg.exc_mag <= RST_EXC_MAG;
			state_reg.exc_route <= RST_EXC_ROUTE;
			state_reg.irq_status <= '0;
			state_reg.irq_mask <= RST_IRQ_MASK[EV_W-1:0];
			state_reg.rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	assign RDATA = state_reg.rdata;
	assign IRQ = |(state_reg.irq_status & state_reg.irq_mask);

	// single bus steps; the ref and mag pairs chain into write-then-read checks
	sequence s_ref_write;
		WR && ADDR == ADDR_REF_CTRL;
	endsequence
	sequence s_ref_read;
		RD && ADDR == ADDR_REF_CTRL;
	endsequence
	sequence s_mag_write;
		WR && ADDR == ADDR_EXC_MAG;
	endsequence
	sequence s_mag_read;
		RD && ADDR == ADDR_EXC_MAG;
	endsequence
	sequence s_route_write;
		WR && ADDR == ADDR_EXC_ROUTE;
	endsequence

	// monitor code decode
	a_mon_off: assert property (
		state_reg.ref_ctrl[MON_MSB:MON_LSB] == 2'b00 |->
		!REF_LOW_MON_EN && !REF_THIRD_MON_EN && !REF_PULL_EN)
		else $error("monitor code 00 leaves a monitor on");
	a_mon_low_only: assert property (
		state_reg.ref_ctrl[MON_MSB:MON_LSB] == 2'b01 |->
		REF_LOW_MON_EN && !REF_THIRD_MON_EN && !REF_PULL_EN)
		else $error("monitor code 01 decoded wrong");
	a_mon_third: assert property (
		state_reg.ref_ctrl[MON_MSB:MON_LSB] == 2'b10 |->
		REF_LOW_MON_EN && REF_THIRD_MON_EN && !REF_PULL_EN)
		else $error("monitor code 10 decoded wrong");
	a_mon_pull: assert property (
		state_reg.ref_ctrl[MON_MSB:MON_LSB] == 2'b11 |->
		REF_LOW_MON_EN && REF_PULL_EN && !REF_THIRD_MON_EN)
		else $error("monitor code 11 decoded wrong");

	// buffer bypass bits and reference selection
	a_buf_bypass: assert property (
		s_ref_write |=> POS_BUF_EN == !$past(WDATA[POS_BYP_BIT]) &&
		NEG_BUF_EN == !$past(WDATA[NEG_BYP_BIT]))
		else $error("buffer bypass not applied");
	a_ref_src: assert property (
		s_ref_write |=>
		REF_SOURCE == $past(WDATA[SEL_MSB:SEL_LSB]))
		else $error("reference source mismatch");
	a_int_ref_pd: assert property (
		state_reg.ref_ctrl[INT_MSB:INT_LSB] == 2'b01 && POWER_DOWN |->
		!INT_REF_ON)
		else $error("internal reference on in power-down");
	a_int_ref_wake: assert property (
		state_reg.ref_ctrl[INT_MSB:INT_LSB] == 2'b01 && !POWER_DOWN |->
		INT_REF_ON)
		else $error("internal reference off outside power-down");
	a_int_ref_always: assert property (
		state_reg.ref_ctrl[INT_MSB:INT_LSB] == 2'b10 |-> INT_REF_ON)
		else $error("always-on internal reference is off");
	a_int_ref_off: assert property (
		state_reg.ref_ctrl[INT_MSB:INT_LSB] == 2'b00 |-> !INT_REF_ON)
		else $error("internal reference on while configured off");
	a_ref_write_read: assert property (
		s_ref_write ##1 s_ref_read |=> RDATA == $past(WDATA, 2))
		else $error("reference control readback mismatch");

	// magnitude register: rail monitor, switch, reserved bits, current
	a_rail_mon: assert property (
		s_mag_write |=> AMP_RAIL_MON_EN == $past(WDATA[RAIL_BIT]))
		else $error("rail monitor enable not applied");
	a_pd_switch_open: assert property (
		POWER_DOWN |-> !LOW_SIDE_SWITCH)
		else $error("low-side switch closed in power-down");
	a_switch_closed: assert property (
		state_reg.exc_mag[SW_BIT] && !POWER_DOWN |-> LOW_SIDE_SWITCH)
		else $error("low-side switch not closed");
	a_mag_rsv_zero: assert property (
		s_mag_read |=> RDATA[5:4] == 2'b00)
		else $error("reserved magnitude bits read nonzero");
	a_mag_write_read: assert property (
		s_mag_write ##1 s_mag_read |=>
		RDATA[MAG_MSB:MAG_LSB] == $past(WDATA[MAG_MSB:MAG_LSB], 2))
		else $error("magnitude readback mismatch");
	a_mag_both: assert property (
		state_reg.exc_mag[MAG_MSB:MAG_LSB] == 4'h9 |->
		CUR_MAG_UA == 12'd2000)
		else $error("magnitude code 9 not 2000 uA");
	a_mag_zero_off: assert property (
		state_reg.exc_mag[MAG_MSB:MAG_LSB] == 4'h0 |->
		CUR_MAG_UA == 12'd0)
		else $error("magnitude code 0 not off");
	a_mag_off_high: assert property (
		state_reg.exc_mag[MAG_MSB:MAG_LSB] > MAG_MAX_CODE |->
		CUR_MAG_UA == 12'd0)
		else $error("out-of-range magnitude not off");
	a_mag_smallest: assert property (
		state_reg.exc_mag[MAG_MSB:MAG_LSB] == 4'h1 |->
		CUR_MAG_UA == 12'd10)
		else $error("magnitude code 1 not 10 uA");

	// routing codes: pins below 1100, common at 1100, open above
	a_route_write: assert property (
		s_route_write |=>
		SRC1_COMMON == ($past(WDATA[ROUTE1_MSB:ROUTE1_LSB]) == ROUTE_COMMON)
		&& SRC2_COMMON ==
		($past(WDATA[ROUTE2_MSB:ROUTE2_LSB]) == ROUTE_COMMON))
		else $error("routing fields not applied");
	a_route_pin: assert property (
		state_reg.exc_route[ROUTE1_MSB:ROUTE1_LSB] < ROUTE_COMMON |->
		$onehot(SRC1_PIN_SEL) && !SRC1_COMMON)
		else $error("first source pin select not one-hot");
	a_route_common: assert property (
		state_reg.exc_route[ROUTE1_MSB:ROUTE1_LSB] == ROUTE_COMMON |->
		SRC1_COMMON && SRC1_PIN_SEL == 12'h000)
		else $error("first source common input not selected");
	a_route_disc: assert property (
		state_reg.exc_route[ROUTE1_MSB:ROUTE1_LSB] > ROUTE_COMMON |->
		SRC1_PIN_SEL == 12'h000 && !SRC1_COMMON)
		else $error("disconnected code drives a pin");
	a_route2_pin: assert property (
		state_reg.exc_route[ROUTE2_MSB:ROUTE2_LSB] < ROUTE_COMMON |->
		$onehot(SRC2_PIN_SEL) && !SRC2_COMMON)
		else $error("second source pin select not one-hot");
	a_route2_common: assert property (
		state_reg.exc_route[ROUTE2_MSB:ROUTE2_LSB] == ROUTE_COMMON |->
		SRC2_COMMON && SRC2_PIN_SEL == 12'h000)
		else $error("second source common input not selected");
	a_route_disc2: assert property (
		state_reg.exc_route[ROUTE2_MSB:ROUTE2_LSB] > ROUTE_COMMON |->
		SRC2_PIN_SEL == 12'h000 && !SRC2_COMMON)
		else $error("disconnected second code drives a pin");

	// misuse flags become sticky status bits on the next edge
	a_status_intref: assert property (
		events[EV_NO_INTREF] |=> state_reg.irq_status[EV_NO_INTREF])
		else $error("current without internal reference not flagged");
	a_status_buf: assert property (
		events[EV_BUF_CONFLICT] |=> state_reg.irq_status[EV_BUF_CONFLICT])
		else $error("buffer conflict not flagged");
endmodule // refexc_ctrl
`default_nettype wire

// [verilog/refexc_route_dec.sv]
// Purpose: decode one 4-bit current routing code into a one-hot pin select
// Assumes: codes 0..11 are input pins, 12 is the common input
// Notes: codes 13..15 leave the source disconnected
`timescale 1ns/10ps
`default_nettype none
module refexc_route_dec
	import refexc_pkg::*;
(
	input wire logic [3:0] code,
	output logic [11:0] pin_sel,
	output logic common_sel,
	output logic connected
);
	always_comb begin
		pin_sel = '0;
		if (code < ROUTE_COMMON) begin
			pin_sel[code] = 1'b1;
		end
	end
	assign common_sel = (code == ROUTE_COMMON);
	assign connected = (code <= ROUTE_COMMON);
endmodule // refexc_route_dec
`default_nettype wire
